// [pkg/tlp_counter_pkg.sv]
// Register map, field layout, event codes and event carriers for the TLP counters
package tlp_counter_pkg;
	localparam int          ADDR_W       = 16;
	localparam logic [15:0] OFF_FUNC_TAG = 16'h5B08;
	localparam logic [15:0] OFF_CTRL     = 16'h5B10;
	localparam logic [15:0] OFF_EVMAP    = 16'h5B14;
	localparam logic [15:0] OFF_CNT0     = 16'h5B20;
	localparam logic [15:0] OFF_CNT1     = 16'h5B24;
	localparam logic [15:0] OFF_CNT2     = 16'h5B28;
	localparam logic [15:0] OFF_CNT3     = 16'h5B2C;
	localparam int          CTRL_START   = 31;
	localparam int          CTRL_STOP    = 30;
	localparam int          CTRL_RESET   = 29;
	localparam int          CTRL_M64     = 28;
	localparam int          CTRL_TEST    = 27;
	localparam int          FT_FUNC_LSB  = 0;
	localparam int          FT_TAG_LSB   = 5;
	localparam logic [31:0] RST_WORD     = 32'h0000_0000;
	localparam logic [7:0]  EV_TX_DW     = 8'h00;
	localparam logic [7:0]  EV_TX_PKT    = 8'h01;
	localparam logic [7:0]  EV_TX_F0     = 8'h02;
	localparam logic [7:0]  EV_TX_F1     = 8'h03;
	localparam logic [7:0]  EV_TX_NP_F0  = 8'h04;
	localparam logic [7:0]  EV_TX_NP_F1  = 8'h05;
	localparam logic [7:0]  EV_TX_FT     = 8'h06;
	localparam logic [7:0]  EV_RX_PKT    = 8'h1A;
	localparam logic [7:0]  EV_RX_F0     = 8'h1B;
	localparam logic [7:0]  EV_RSVD      = 8'h1C;
	localparam logic [7:0]  EV_RX_CPL_FT = 8'h1D;
	localparam logic [7:0]  EV_CLK       = 8'h20;
	localparam logic [7:0]  EV_RX_BAD    = 8'h21;
	localparam logic [7:0]  EV_TX_HDR    = 8'h25;
	localparam logic [7:0]  EV_RX_HDR    = 8'h26;

	typedef struct packed {
		logic       sop;
		logic [1:0] dw;
		logic [1:0] hdrDw;
		logic       replay;
		logic       isCpl;
		logic       isMem;
		logic       isMsg;
		logic       nonPosted;
		logic [4:0] func;
		logic [2:0] tag;
	} tx_ev_t;

	typedef struct packed {
		logic       sop;
		logic [1:0] hdrDw;
		logic       isCpl;
		logic       isMem;
		logic       isIo;
		logic       isCfg;
		logic       isMsg;
		logic       good;
		logic       bad;
		logic [4:0] func;
		logic [2:0] tag;
	} rx_ev_t;
endpackage : tlp_counter_pkg

// [core/tlp_event_counters.sv]
// Four TLP event counters with an Avalon-MM register slave
`timescale 1ns/1ns
module tlp_event_counters
	import tlp_counter_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// Transaction layer events
	input  wire tx_ev_t            txEv,
	input  wire rx_ev_t            rxEv
);
	logic        ack_r;
	logic [31:0] rdData_r;
	logic [31:0] funcTag_r;
	logic [31:0] evMap_r;
	logic [3:0]  en_r;
	logic        running_r;
	logic        m64_r;
	logic        test_r;
	logic [31:0] cnt [4];
	logic [3:0]  carry;
	logic        wrAck;
	logic [31:0] beMask;
	logic [31:0] ctrlImg;
	logic [31:0] ctrlNew;
	logic        cntRst;

	// One wait cycle: read data is registered before it is presented
	assign waitrequest = (read | write) & ~ack_r;
	assign readdata    = rdData_r;
	assign wrAck       = write & ack_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (read | write) & ~ack_r;
		end
	end

	always_comb begin
		beMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
		ctrlImg = {running_r, 2'b00, m64_r, test_r, 23'h00_0000, en_r};
		ctrlNew = (ctrlImg & ~beMask) | (writedata & beMask);
	end

	// Reset bit acts as a pulse; it is not stored
	assign cntRst = wrAck & (address == OFF_CTRL) & byteenable[3] & writedata[CTRL_RESET];

	always_ff @(posedge clk) begin
		if (srst) begin
			rdData_r <= RST_WORD;
		end else if (read & ~ack_r) begin
			case (address)
				OFF_FUNC_TAG: rdData_r <= funcTag_r;
				OFF_CTRL:     rdData_r <= ctrlImg;
				OFF_EVMAP:    rdData_r <= evMap_r;
				OFF_CNT0:     rdData_r <= cnt[0];
				OFF_CNT1:     rdData_r <= cnt[1];
				OFF_CNT2:     rdData_r <= cnt[2];
				OFF_CNT3:     rdData_r <= cnt[3];
				default:      rdData_r <= RST_WORD;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			funcTag_r <= RST_WORD;
		end else if (wrAck && address == OFF_FUNC_TAG) begin
			funcTag_r <= (funcTag_r & ~beMask) | (writedata & beMask);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			evMap_r <= RST_WORD;
		end else if (wrAck && address == OFF_EVMAP) begin
			evMap_r <= (evMap_r & ~beMask) | (writedata & beMask);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			running_r <= 1'b0;
			m64_r     <= 1'b0;
			test_r    <= 1'b0;
			en_r      <= 4'h0;
		end else if (wrAck && address == OFF_CTRL) begin
			// Stop wins when both are written together
			if (byteenable[3] && writedata[CTRL_STOP]) begin
				running_r <= 1'b0;
			end else if (byteenable[3] && writedata[CTRL_START]) begin
				running_r <= 1'b1;
			end
			m64_r  <= ctrlNew[CTRL_M64];
			test_r <= ctrlNew[CTRL_TEST];
			en_r   <= ctrlNew[3:0];
		end
	end

	function automatic logic [1:0] evInc(input logic [7:0] code, input logic [7:0] ft);
		logic txOk;
		logic txMm;
		logic ftTx;
		logic ftRx;
		logic goodCpl;
		txOk    = txEv.sop & ~txEv.replay;
		txMm    = txOk & (txEv.isMem | txEv.isMsg);
		ftTx    = (txEv.func == ft[FT_TAG_LSB-1:FT_FUNC_LSB]) && (txEv.tag == ft[7:FT_TAG_LSB]);
		ftRx    = (rxEv.func == ft[FT_TAG_LSB-1:FT_FUNC_LSB]) && (rxEv.tag == ft[7:FT_TAG_LSB]);
		goodCpl = rxEv.sop & rxEv.isCpl & rxEv.good;
		case (code)
			EV_TX_DW:     evInc = (~txEv.replay & (txEv.isCpl | txEv.isMem | txEv.isMsg))
			                      ? txEv.dw : 2'd0;
			EV_TX_PKT:    evInc = {1'b0, txOk & (txEv.isCpl | txEv.isMem | txEv.isMsg)};
			EV_TX_F0:     evInc = {1'b0, txMm & (txEv.func == 5'h00)};
			EV_TX_F1:     evInc = {1'b0, txMm & (txEv.func == 5'h01)};
			EV_TX_NP_F0:  evInc = {1'b0, txOk & txEv.isMem & txEv.nonPosted
			                      & (txEv.func == 5'h00)};
			EV_TX_NP_F1:  evInc = {1'b0, txOk & txEv.isMem & txEv.nonPosted
			                      & (txEv.func == 5'h01)};
			EV_TX_FT:     evInc = {1'b0, txMm & ftTx};
			EV_RX_PKT:    evInc = {1'b0, goodCpl | (rxEv.sop
			                      & (rxEv.isMem | rxEv.isIo | rxEv.isCfg))};
			EV_RX_F0:     evInc = {1'b0, goodCpl & (rxEv.func == 5'h00)};
			EV_RX_CPL_FT: evInc = {1'b0, goodCpl & ftRx};
			EV_CLK:       evInc = 2'd1;
			EV_RX_BAD:    evInc = {1'b0, rxEv.bad};
			EV_TX_HDR:    evInc = (~txEv.replay & (txEv.isCpl | txEv.isMem | txEv.isMsg))
			                      ? txEv.hdrDw : 2'd0;
			EV_RX_HDR:    evInc = (rxEv.isCpl | rxEv.isMem | rxEv.isMsg)
			                      ? rxEv.hdrDw : 2'd0;
			default:      evInc = 2'd0;
		endcase
	endfunction : evInc

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cnt
			logic [31:0] c_r;
			logic [1:0]  add;
			logic [32:0] sum;
			logic        hiHalf;
			logic        carryIn;
			// Odd counters become the upper word of the pair below in 64-bit mode
			assign hiHalf = m64_r && (gi % 2 == 1);
			// Even counters take no carry, so no false loop runs round the chain
			if (gi % 2 == 1) begin : g_hi
				assign carryIn = carry[gi-1];
			end else begin : g_lo
				assign carryIn = 1'b0;
			end
			always_comb begin
				if (hiHalf) begin
					add = {1'b0, carryIn};
				end else if (running_r && en_r[gi]) begin
					add = evInc(evMap_r[gi*8 +: 8], funcTag_r[gi*8 +: 8]);
				end else begin
					add = 2'd0;
				end
				sum = {1'b0, c_r} + {31'h0000_0000, add};
			end
			assign carry[gi] = sum[32];
			assign cnt[gi]   = c_r;
			always_ff @(posedge clk) begin
				if (srst || cntRst) begin
					c_r <= RST_WORD;
				end else if (wrAck && address == OFF_CNT0 + 16'(gi * 4)) begin
					c_r <= (c_r & ~beMask) | (writedata & beMask);
				end else begin
					c_r <= sum[31:0];
				end
			end
		end
	endgenerate

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	logic act0;
	logic act1;
	assign act0 = running_r & en_r[0] & ~m64_r & ~wrAck;
	assign act1 = running_r & en_r[1] & ~m64_r & ~wrAck;

	property p_bus_wait;
		(read | write) & ~ack_r |=> ~waitrequest;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("waitrequest not released");

	property p_tx_dw;
		act0 && evMap_r[7:0] == EV_TX_DW && !txEv.replay && txEv.isMem
		|=> cnt[0] == $past(cnt[0]) + 32'($past(txEv.dw));
	endproperty
	a_tx_dw: assert property (p_tx_dw) else $error("dword count wrong");

	property p_tx_pkt_replay;
		act0 && evMap_r[7:0] == EV_TX_PKT && txEv.replay |=> cnt[0] == $past(cnt[0]);
	endproperty
	a_tx_pkt_replay: assert property (p_tx_pkt_replay) else $error("replay counted");

	property p_bad;
		act0 && evMap_r[7:0] == EV_RX_BAD && rxEv.bad |=> cnt[0] == $past(cnt[0]) + 32'd1;
	endproperty
	a_bad: assert property (p_bad) else $error("bad packet missed");

	property p_reserved;
		act0 && evMap_r[7:0] == EV_RSVD |=> cnt[0] == $past(cnt[0]);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code counted");

	property p_map1;
		act1 && evMap_r[15:8] == EV_CLK [*2] |=> cnt[1] == $past(cnt[1], 2) + 32'd2;
	endproperty
	a_map1: assert property (p_map1) else $error("counter 1 clock event wrong");

	property p_stopped;
		!running_r && !wrAck |=> $stable(cnt[2]);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counted while stopped");

	property p_reset;
		cntRst |=> cnt[0] == RST_WORD && cnt[3] == RST_WORD;
	endproperty
	a_reset: assert property (p_reset) else $error("reset bit ignored");

	property p_carry;
		m64_r && !wrAck && !cntRst && g_cnt[0].add != 2'd0 && cnt[0] == 32'hFFFF_FFFF
		|=> cnt[1] == $past(cnt[1]) + 32'd1;
	endproperty
	a_carry: assert property (p_carry) else $error("64-bit carry lost");

	property p_wrap;
		act0 && evMap_r[7:0] == EV_CLK && cnt[0] == 32'hFFFF_FFFF |=> cnt[0] == RST_WORD;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_dw_replay;
		act0 && evMap_r[7:0] == EV_TX_DW && txEv.replay |=> cnt[0] == $past(cnt[0]);
	endproperty
	a_dw_replay: assert property (p_dw_replay) else $error("replay dwords counted");

	property p_pkt_sop;
		act0 && evMap_r[7:0] == EV_TX_PKT && !txEv.sop |=> cnt[0] == $past(cnt[0]);
	endproperty
	a_pkt_sop: assert property (p_pkt_sop) else $error("packet counted off start");

	property p_np_f0;
		act0 && evMap_r[7:0] == EV_TX_NP_F0 && txEv.sop && !txEv.replay && txEv.isMem
		&& txEv.nonPosted && txEv.func == 5'h00 |=> cnt[0] == $past(cnt[0]) + 32'd1;
	endproperty
	a_np_f0: assert property (p_np_f0) else $error("non-posted packet missed");

	property p_rx_f0_bad;
		act0 && evMap_r[7:0] == EV_RX_F0 && rxEv.isCpl && !rxEv.good
		|=> cnt[0] == $past(cnt[0]);
	endproperty
	a_rx_f0_bad: assert property (p_rx_f0_bad) else $error("bad completion counted");

	property p_cpl_ft;
		act1 && evMap_r[15:8] == EV_RX_CPL_FT && rxEv.sop && rxEv.isCpl && rxEv.good
		&& rxEv.func == funcTag_r[12:8] && rxEv.tag == funcTag_r[15:13]
		|=> cnt[1] == $past(cnt[1]) + 32'd1;
	endproperty
	a_cpl_ft: assert property (p_cpl_ft) else $error("matching completion missed");

	property p_disabled;
		running_r && !en_r[3] && !m64_r && !wrAck |=> $stable(cnt[3]);
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled counter moved");

	property p_hi_frozen;
		m64_r && !wrAck && !carry[0] |=> $stable(cnt[1]);
	endproperty
	a_hi_frozen: assert property (p_hi_frozen) else $error("upper half moved");

	property p_unassigned;
		act1 && evMap_r[15:8] == 8'h7F |=> $stable(cnt[1]);
	endproperty
	a_unassigned: assert property (p_unassigned) else $error("unassigned code counted");

	c_write: cover property (wrAck && address == OFF_CTRL);
	c_count: cover property (act0 && g_cnt[0].add == 2'd2);
	c_carry: cover property (m64_r && carry[0]);
	c_wrap:  cover property (act0 && evMap_r[7:0] == EV_CLK && cnt[0] == 32'hFFFF_FFFF);
	c_bad:   cover property (act0 && evMap_r[7:0] == EV_RX_BAD && rxEv.bad);
endmodule : tlp_event_counters

// [test/tlp_link_model.sv]
// Behavioural transaction layer source driving the event inputs
`timescale 1ns/1ns
module tlp_link_model
	import tlp_counter_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Stimulus
	input  wire logic        go,
	input  wire logic [31:0] rnd,
	// Event words
	output tx_ev_t           txEv,
	output rx_ev_t           rxEv
);
	logic [1:0] dwSel;
	tx_ev_t     txEv_nxt;
	rx_ev_t     rxEv_nxt;
	assign dwSel = rnd[1] ? 2'h2 : {1'b0, rnd[2]};
	// At most one type flag per word; all quiet while idle so idle cycles add only to EV_CLK counts
	always_comb begin
		txEv_nxt = '0;
		rxEv_nxt = '0;
		if (!srst && go) begin
			txEv_nxt.sop       = rnd[0];
			txEv_nxt.dw        = dwSel;
			txEv_nxt.hdrDw     = rnd[3] ? 2'h0 : dwSel;
			txEv_nxt.replay    = rnd[4] & rnd[5];
			txEv_nxt.isCpl     = rnd[7:6] == 2'h0;
			txEv_nxt.isMem     = rnd[7:6] == 2'h1;
			txEv_nxt.isMsg     = rnd[7:6] == 2'h2;
			txEv_nxt.nonPosted = rnd[8];
			txEv_nxt.func      = {4'h0, rnd[9]};
			txEv_nxt.tag       = rnd[12:10];
			rxEv_nxt.sop       = rnd[13];
			rxEv_nxt.hdrDw     = rnd[14] ? 2'h2 : {1'b0, rnd[15]};
			rxEv_nxt.isCpl     = rnd[18:16] == 3'h0;
			rxEv_nxt.isMem     = rnd[18:16] == 3'h1;
			rxEv_nxt.isIo      = rnd[18:16] == 3'h2;
			rxEv_nxt.isCfg     = rnd[18:16] == 3'h3;
			rxEv_nxt.isMsg     = rnd[18:16] == 3'h4;
			rxEv_nxt.good      = rnd[19] | rnd[20];
			rxEv_nxt.bad       = rnd[21] & rnd[22];
			rxEv_nxt.func      = {4'h0, rnd[23]};
			rxEv_nxt.tag       = rnd[26:24];
		end
	end
	// One update per edge keeps each word single-assigned
	always_ff @(posedge clk) begin
		txEv <= txEv_nxt;
		rxEv <= rxEv_nxt;
	end
endmodule : tlp_link_model

// [test/test_pcie_tlp_event_counters.sv]
// Self-checking bench for the TLP event counters
`timescale 1ns/1ns
module test_pcie_tlp_event_counters
	import tlp_counter_pkg::*;
;
	logic        clk, srst, read, write, waitrequest, go, track, m64M;
	logic [15:0] address;
	logic [31:0] writedata, readdata, lfsrR, mapM, ftM, q;
	logic [3:0]  byteenable, enM;
	tx_ev_t      txEv;
	rx_ev_t      rxEv;
	logic [31:0] mdl [4];
	int          err_total, checks, cyc;

	tlp_event_counters dut (.clk, .srst, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .txEv, .rxEv);
	tlp_link_model link (.clk, .srst, .go, .rnd(lfsrR), .txEv, .rxEv);

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRnd

	function automatic logic [31:0] evInc(input logic [7:0] c, input logic [7:0] ft);
		logic okT, mmT, cpR;
		okT = !txEv.replay && (txEv.isCpl || txEv.isMem || txEv.isMsg);
		mmT = txEv.sop && !txEv.replay && (txEv.isMem || txEv.isMsg);
		cpR = rxEv.sop && rxEv.isCpl && rxEv.good;
		case (c)
			EV_TX_DW:     return okT ? 32'(txEv.dw) : 0;
			EV_TX_PKT:    return 32'(okT && txEv.sop);
			EV_TX_F0:     return 32'(mmT && txEv.func == 0);
			EV_TX_F1:     return 32'(mmT && txEv.func == 1);
			EV_TX_NP_F0:  return 32'(mmT && txEv.isMem && txEv.nonPosted && txEv.func == 0);
			EV_TX_NP_F1:  return 32'(mmT && txEv.isMem && txEv.nonPosted && txEv.func == 1);
			EV_TX_FT:     return 32'(mmT && txEv.func == ft[4:0] && txEv.tag == ft[7:5]);
			EV_RX_PKT:    return 32'(rxEv.sop && (rxEv.isMem || rxEv.isIo || rxEv.isCfg) || cpR);
			EV_RX_F0:     return 32'(cpR && rxEv.func == 0);
			EV_RX_CPL_FT: return 32'(cpR && rxEv.func == ft[4:0] && rxEv.tag == ft[7:5]);
			EV_CLK:       return 1;
			EV_RX_BAD:    return 32'(rxEv.bad);
			EV_TX_HDR:    return okT ? 32'(txEv.hdrDw) : 0;
			EV_RX_HDR:    return (rxEv.isCpl || rxEv.isMem || rxEv.isMsg) ? 32'(rxEv.hdrDw) : 0;
			default:      return 0;
		endcase
	endfunction : evInc

	// Reference counters; 32-bit sums, 64-bit across a pair in 64-bit mode, wrap like the hardware
	always @(posedge clk) begin
		lfsrR <= nextRnd(lfsrR);
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			test_done();
		end
		if (track && m64M) begin
			if (enM[0]) {mdl[1], mdl[0]} <= {mdl[1], mdl[0]} + 64'(evInc(mapM[7:0], ftM[7:0]));
			if (enM[2]) {mdl[3], mdl[2]} <= {mdl[3], mdl[2]} + 64'(evInc(mapM[23:16], ftM[23:16]));
		end else if (track) begin
			for (int i = 0; i < 4; i++)
				if (enM[i]) mdl[i] <= mdl[i] + evInc(mapM[8*i+:8], ftM[8*i+:8]);
		end
	end

	task automatic test_done();
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Held until waitrequest is seen low at a rising edge
	task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		address   <= a;
		writedata <= d;
		write     <= w;
		read      <= !w;
		@(posedge clk);
		chk(32'(waitrequest), 32'h0000_0001);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		r = readdata;
		read  <= 0;
		write <= 0;
	endtask : bus

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		bus(a, 1, d, q);
	endtask : wr

	task automatic run(input logic [31:0] map, input logic [3:0] en, input logic m,
		input logic [31:0] pre);
		logic [31:0] ctl;
		ctl = {3'b000, m, 28'(en)};
		wr(OFF_CTRL, ctl | 32'h2000_0000);
		wr(OFF_EVMAP, map);
		bus(OFF_EVMAP, 0, 0, q);
		chk(q, map);
		ftM = lfsrR & 32'hE1E1_E1E1;
		wr(OFF_FUNC_TAG, ftM);
		bus(OFF_FUNC_TAG, 0, 0, q);
		chk(q, ftM);
		wr(OFF_CNT0, pre);
		mdl = '{pre, 0, 0, 0};
		mapM = map;
		enM = en;
		m64M = m;
		// Model counts from the edge after the start lands up to the stop edge
		wr(OFF_CTRL, ctl | 32'h8000_0000);
		track <= 1;
		bus(OFF_CTRL, 0, 0, q);
		chk(q, ctl | 32'h8000_0000);
		go <= 1;
		repeat (150) @(posedge clk);
		go <= 0;
		repeat (3) @(posedge clk);
		wr(OFF_CTRL, ctl | 32'h4000_0000);
		track <= 0;
		bus(OFF_CTRL, 0, 0, q);
		chk(q, ctl);
		for (int i = 0; i < 4; i++) begin
			bus(OFF_CNT0 + 16'(4 * i), 0, 0, q);
			chk(q, mdl[i]);
		end
	endtask : run

	initial begin
		logic [15:0] offs [8];
		offs = '{OFF_FUNC_TAG, OFF_CTRL, OFF_EVMAP, OFF_CNT0, OFF_CNT1, OFF_CNT2, OFF_CNT3, 16'h5B30};
		srst = 1;
		{read, write, go, track, m64M} = '0;
		{address, writedata, mapM, ftM, enM} = '0;
		byteenable = 4'hF;
		lfsrR = 32'h0000_0045;
		{err_total, checks, cyc} = '0;
		mdl = '{default: '0};
		repeat (2) @(posedge clk);
		srst <= 0;
		wr(16'h5B30, 32'hFFFF_FFFF);
		foreach (offs[i]) begin
			bus(offs[i], 0, 0, q);
			chk(q, 32'h0000_0000);
		end
		// Single lane write leaves the other bytes alone
		byteenable <= 4'h1;
		wr(OFF_EVMAP, 32'hFFFF_FFFF);
		byteenable <= 4'hF;
		bus(OFF_EVMAP, 0, 0, q);
		chk(q, 32'h0000_00FF);
		// Stop beats start in one write; test bit is only stored
		wr(OFF_CTRL, 32'hC800_0000);
		bus(OFF_CTRL, 0, 0, q);
		chk(q, 32'h0800_0000);
		run(32'h0302_0100, 4'hF, 0, 32'h0000_0000);
		run(32'h1A06_0504, 4'hF, 0, 32'h0000_0000);
		run(32'h2521_1D1B, 4'hF, 0, 32'h0000_0000);
		run(32'h2626_7F1C, 4'h7, 0, 32'h0000_0000);
		run(32'h0101_0101, 4'hF, 0, 32'hFFFF_FFF8);
		run(32'h0025_0000, 4'h5, 1, 32'hFFFF_FF00);
		run(32'h1D1B_1A21, 4'hF, 0, 32'h0000_0000);
		run(32'h0020_2020, 4'h7, 0, 32'hFFFF_FFF0);
		run(32'h0000_0020, 4'h1, 1, 32'hFFFF_FFF0);
		test_done();
	end
endmodule : test_pcie_tlp_event_counters
